/* File: logic/motion_cfg.svh */
`ifndef MOTION_CFG_SVH
`define MOTION_CFG_SVH
// Command bytes
`define CMD_LOAD_TRAJ   8'h1F
`define CMD_START       8'h01
`define CMD_LOAD_FILT   8'h1E
`define CMD_COMMIT_FILT 8'h04
`define CMD_INT_MASK    8'h1C
`define CMD_INT_CLEAR   8'h1D
`define CMD_ARM_INDEX   8'h03
`define CMD_RD_INDEX    8'h09
`define CMD_ERR_FLAG    8'h1B
`define CMD_ERR_STOP    8'h1A
`define CMD_BP_ABS      8'h20
`define CMD_BP_REL      8'h21
`define CMD_RD_SIGNALS  8'h0C
`define CMD_RD_DES_POS  8'h08
`define CMD_RD_ACT_POS  8'h0A
`define CMD_RD_DES_VEL  8'h07
`define CMD_RD_ACT_VEL  8'h0B
`define CMD_RD_INTEGRAL 8'h0D
// Trajectory control word fields
`define TCW_POS_REL     0
`define TCW_POS_LOAD    1
`define TCW_VEL_REL     2
`define TCW_VEL_LOAD    3
`define TCW_ACC_REL     4
`define TCW_ACC_LOAD    5
`define TCW_MOTOR_OFF   8
// Status byte and signals word fields
`define ST_MOTOR_OFF    7
`define SIG_TRAJ_DONE   10
`define SIG_HOST_INT    15
`define STATUS_RESET    8'h84
// Synchroniser idle value: index, select, strobes high
`define PIN_IDLE        13'h1F00
// Derivative interval step in clock periods
`define DERIV_STEP_CYCLES 2048
`endif

/* File: logic/motion_pkg.sv */
package motion_pkg;
	typedef enum logic {CMD_WAIT, WORD_WAIT} cmd_phase_t;

	typedef struct packed {
		logic [12:0] s1;
		logic [12:0] s2;
		logic [12:0] s3;
		logic [12:0] stable;
		logic [12:0] prev;
	} pin_sync_t;

	typedef struct packed {
		cmd_phase_t  phase;
		logic [7:0]  cmd;
		logic        hi_done;
		logic [7:0]  hi_byte;
		logic [3:0]  words_left;
		logic [3:0]  word_idx;
		logic        busy;
		logic [15:0] tcw_buf;
		logic [31:0] acc_buf;
		logic [31:0] vel_buf;
		logic [31:0] pos_buf;
		logic        acc_new;
		logic [15:0] tcw_w;
		logic [31:0] acc_w;
		logic [31:0] vel_w;
		logic [31:0] pos_w;
		logic        start_p;
		logic [3:0]  fsel;
		logic [7:0]  dint_b;
		logic [15:0] kp_b;
		logic [15:0] ki_b;
		logic [15:0] kd_b;
		logic [15:0] il_b;
		logic [7:0]  dint_w;
		logic [15:0] kp_w;
		logic [15:0] ki_w;
		logic [15:0] kd_w;
		logic [15:0] il_w;
		logic [19:0] dcnt;
		logic        dtick;
		logic [6:1]  flags;
		logic [6:1]  mask;
		logic        motor_off;
		logic        traj_done;
		logic        host_int;
		logic        idx_armed;
		logic [31:0] idx_pos;
		logic [15:0] err_lim;
		logic        err_en;
		logic        err_stop;
		logic [31:0] bp_pos;
		logic        bp_en;
		logic [17:0] isum;
		logic [31:0] rbuf;
		logic [7:0]  out_byte;
	} core_state_t;
endpackage : motion_pkg

/* File: logic/host_link_if.sv */
`timescale 1ns/100ps
interface host_link_if;
	logic       cmd_strobe;
	logic       data_strobe;
	logic [7:0] byte_val;
	logic       rd_advance;
	logic       read_status;
	logic       drive;
	logic       index_edge;
	modport front (output cmd_strobe, data_strobe, byte_val, rd_advance,
		read_status, drive, index_edge);
	modport core (input cmd_strobe, data_strobe, byte_val, rd_advance,
		read_status, drive, index_edge);
endinterface : host_link_if

/* File: logic/host_pin_front.sv */
`timescale 1ns/100ps
`include "motion_cfg.svh"
module host_pin_front
	import motion_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	// Raw pins
	input  wire logic       cs_n,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic       port_select_n,
	input  wire logic       index_n,
	input  wire logic [7:0] data_in,
	// Decoded events
	host_link_if.front      link
);
	pin_sync_t s_r;
	pin_sync_t s_nxt;
	logic [12:0] agree;

	////////////////////////////////////////////////////////////////////
	// Three-stage capture; a change counts once stages two and three agree
	always_comb begin
		s_nxt = s_r;
		agree = ~(s_r.s2 ^ s_r.s3);
		s_nxt.s1 = {index_n, port_select_n, cs_n, rd_n, wr_n, data_in};
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		s_nxt.stable = (agree & s_r.s3) | (~agree & s_r.stable);
		s_nxt.prev = s_r.stable;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '{s1: `PIN_IDLE, s2: `PIN_IDLE, s3: `PIN_IDLE,
				stable: `PIN_IDLE, prev: `PIN_IDLE};
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Byte taken on the trailing edge of write, data still held then
	assign link.cmd_strobe  = ~s_r.prev[8] & s_r.stable[8] &
		~s_r.prev[10] & ~s_r.prev[11];
	assign link.data_strobe = ~s_r.prev[8] & s_r.stable[8] &
		~s_r.prev[10] & s_r.prev[11];
	assign link.byte_val    = s_r.prev[7:0];
	assign link.rd_advance  = ~s_r.prev[9] & s_r.stable[9] &
		~s_r.prev[10] & s_r.prev[11];
	assign link.read_status = ~s_r.stable[10] & ~s_r.stable[9] &
		~s_r.stable[11];
	assign link.drive       = ~s_r.stable[10] & ~s_r.stable[9];
	assign link.index_edge  = s_r.prev[12] & ~s_r.stable[12];
endmodule : host_pin_front

/* File: logic/motion_host_command_interface.sv */
// Summary of operation
// - Trajectory words follow: acceleration, velocity, position
// - Each word sent high byte then low
// - Start commits buffered trajectory and begins move
// - Changed acceleration with drive on and move not done: error, ignored
// - Filter high byte sets derivative interval steps
// - Filter low nibble selects which values follow
// - Filter values apply only on commit command
// - Integral clamped to limit; read returns magnitude
// - Status: busy, six events, motor off
// - Mask pair enables flags onto host interrupt
// - Clear pair: zero bit clears matching flag
// - Armed index latches position, sets bit 3
// - Error limit sets bit 5, optionally stops
// - Breakpoint sets bit 6; relative adds target
// - Events set bits 1, 2 and 4
// - Masked flags still visible in status
// - Status read directly by select and read low
// - Signals word: armed index, done, interrupt
// - Desired and actual position reads, 32 bits
// - Desired velocity 32 bits, actual 16 bits
`timescale 1ns/100ps
`include "motion_cfg.svh"
module motion_host_command_interface
	import motion_pkg::*;
#(
	parameter int DERIV_STEP = `DERIV_STEP_CYCLES
)(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	// Host port
	input  wire logic        cs_n,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic        port_select_n,
	input  wire logic [7:0]  data_in,
	output logic [7:0]       data_out,
	output logic             data_oe,
	output logic             host_int,
	// Encoder index pin
	input  wire logic        index_n,
	// Loop values from motion core
	input  wire logic [31:0] desired_position,
	input  wire logic [31:0] actual_position,
	input  wire logic [31:0] desired_velocity,
	input  wire logic [15:0] actual_velocity,
	input  wire logic        traj_done_in,
	input  wire logic        wrap_in,
	input  wire logic        err_sample_valid,
	input  wire logic [15:0] err_sample,
	// Working trajectory
	output logic [31:0]      acc_work,
	output logic [31:0]      vel_work,
	output logic [31:0]      pos_work,
	output logic [15:0]      traj_ctrl_work,
	output logic             start_pulse,
	output logic             motor_off,
	// Working filter
	output logic [15:0]      proportional_gain,
	output logic [15:0]      integral_gain,
	output logic [15:0]      derivative_gain,
	output logic [15:0]      integration_limit,
	output logic             deriv_tick,
	output logic [15:0]      integral_sum
);
	host_link_if hl();

	host_pin_front u_front (
		.core_clk      (core_clk),
		.rst_b         (rst_b),
		.cs_n          (cs_n),
		.rd_n          (rd_n),
		.wr_n          (wr_n),
		.port_select_n (port_select_n),
		.index_n       (index_n),
		.data_in       (data_in),
		.link          (hl.front)
	);

	core_state_t s_r;
	core_state_t s_nxt;
	logic [15:0] word;
	logic [3:0]  w;
	logic [3:0]  a2;
	logic [3:0]  v2;
	logic [7:0]  status_byte;
	logic [15:0] signals_word;
	logic [31:0] poserr;
	logic [31:0] poserr_mag;
	logic [17:0] isum_t;
	logic [17:0] il_ext;
	logic [19:0] dend;
	logic        accel_block;

	function automatic logic [1:0] filter_slot(input logic [3:0] sel,
		input logic [3:0] idx);
		logic [3:0] cnt;
		logic [1:0] slot;
		cnt = 4'h0;
		slot = 2'h0;
		for (int b = 3; b >= 0; b--) begin
			if (sel[b]) begin
				if (cnt == idx)
					slot = 2'(3 - b);
				cnt = cnt + 4'h1;
			end
		end
		return slot;
	endfunction : filter_slot

	assign status_byte = {s_r.motor_off, s_r.flags, s_r.busy};
	assign signals_word = {s_r.host_int, 4'h0, s_r.traj_done, 2'h0,
		status_byte[7:1], s_r.idx_armed};
	assign poserr = desired_position - actual_position;
	assign poserr_mag = poserr[31] ? (32'h0 - poserr) : poserr;
	assign il_ext = {2'h0, s_r.il_w};
	assign dend = 20'(({12'h0, s_r.dint_w} + 20'h1) * DERIV_STEP - 1);
	assign accel_block = s_r.acc_new & ~s_r.motor_off & ~s_r.traj_done;

	////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		s_nxt = s_r;
		word = {s_r.hi_byte, hl.byte_val};
		w = s_r.word_idx - 4'h1;
		a2 = s_r.tcw_buf[`TCW_ACC_LOAD] ? 4'h2 : 4'h0;
		v2 = s_r.tcw_buf[`TCW_VEL_LOAD] ? 4'h2 : 4'h0;
		isum_t = 18'h0;
		s_nxt.start_p = 1'b0;
		s_nxt.dtick = 1'b0;
		s_nxt.busy = hl.cmd_strobe | hl.data_strobe;
		if (hl.rd_advance)
			s_nxt.rbuf = {s_r.rbuf[23:0], 8'h00};

		if (hl.cmd_strobe) begin
			s_nxt.cmd = hl.byte_val;
			s_nxt.hi_done = 1'b0;
			s_nxt.word_idx = 4'h0;
			s_nxt.words_left = 4'h1;
			s_nxt.phase = CMD_WAIT;
			case (hl.byte_val)
				`CMD_LOAD_TRAJ, `CMD_LOAD_FILT, `CMD_INT_MASK,
				`CMD_INT_CLEAR, `CMD_ERR_FLAG, `CMD_ERR_STOP: begin
					s_nxt.phase = WORD_WAIT;
				end
				`CMD_BP_ABS, `CMD_BP_REL: begin
					s_nxt.phase = WORD_WAIT;
					s_nxt.words_left = 4'h2;
				end
				`CMD_START: begin
					if (accel_block) begin
						s_nxt.flags[1] = 1'b1;
					end else begin
						if (s_r.tcw_buf[`TCW_ACC_LOAD])
							s_nxt.acc_w = s_r.tcw_buf[`TCW_ACC_REL] ?
								s_r.acc_w + s_r.acc_buf : s_r.acc_buf;
						if (s_r.tcw_buf[`TCW_VEL_LOAD])
							s_nxt.vel_w = s_r.tcw_buf[`TCW_VEL_REL] ?
								s_r.vel_w + s_r.vel_buf : s_r.vel_buf;
						if (s_r.tcw_buf[`TCW_POS_LOAD])
							s_nxt.pos_w = s_r.tcw_buf[`TCW_POS_REL] ?
								s_r.pos_w + s_r.pos_buf : s_r.pos_buf;
						s_nxt.tcw_w = s_r.tcw_buf;
						s_nxt.tcw_buf[5:0] = 6'h00;
						s_nxt.motor_off = s_r.tcw_buf[`TCW_MOTOR_OFF];
						s_nxt.traj_done = 1'b0;
						s_nxt.acc_new = 1'b0;
						s_nxt.start_p = 1'b1;
					end
				end
				`CMD_COMMIT_FILT: begin
					s_nxt.kp_w = s_r.kp_b;
					s_nxt.ki_w = s_r.ki_b;
					s_nxt.kd_w = s_r.kd_b;
					s_nxt.il_w = s_r.il_b;
					s_nxt.dint_w = s_r.dint_b;
				end
				`CMD_ARM_INDEX: s_nxt.idx_armed = 1'b1;
				`CMD_RD_INDEX:  s_nxt.rbuf = s_r.idx_pos;
				`CMD_RD_SIGNALS: s_nxt.rbuf = {signals_word, 16'h0};
				`CMD_RD_DES_POS: s_nxt.rbuf = desired_position;
				`CMD_RD_ACT_POS: s_nxt.rbuf = actual_position;
				`CMD_RD_DES_VEL: s_nxt.rbuf = desired_velocity;
				`CMD_RD_ACT_VEL: s_nxt.rbuf = {actual_velocity, 16'h0};
				`CMD_RD_INTEGRAL: begin
					s_nxt.rbuf = {integral_sum, 16'h0};
				end
				default: s_nxt.flags[1] = 1'b1;
			endcase
		end else if (hl.data_strobe && s_r.phase == WORD_WAIT) begin
			if (!s_r.hi_done) begin
				s_nxt.hi_byte = hl.byte_val;
				s_nxt.hi_done = 1'b1;
			end else begin
				s_nxt.hi_done = 1'b0;
				s_nxt.word_idx = s_r.word_idx + 4'h1;
				s_nxt.words_left = s_r.words_left - 4'h1;
				w = s_r.word_idx - 4'h1;
				case (s_r.cmd)
					`CMD_LOAD_TRAJ: begin
						if (s_r.word_idx == 4'h0) begin
							s_nxt.tcw_buf = word;
							s_nxt.words_left = 4'(({3'h0, word[5]} +
								{3'h0, word[3]} + {3'h0, word[1]}) << 1);
						end else if (w < a2) begin
							s_nxt.acc_new = 1'b1;
							if (!w[0]) s_nxt.acc_buf[31:16] = word;
							else s_nxt.acc_buf[15:0] = word;
						end else if (w < a2 + v2) begin
							if (!w[0]) s_nxt.vel_buf[31:16] = word;
							else s_nxt.vel_buf[15:0] = word;
						end else begin
							if (!w[0]) s_nxt.pos_buf[31:16] = word;
							else s_nxt.pos_buf[15:0] = word;
						end
					end
					`CMD_LOAD_FILT: begin
						if (s_r.word_idx == 4'h0) begin
							s_nxt.dint_b = word[15:8];
							s_nxt.fsel = word[3:0];
							s_nxt.words_left = {3'h0, word[3]} +
								{3'h0, word[2]} + {3'h0, word[1]} +
								{3'h0, word[0]};
						end else begin
							case (filter_slot(s_r.fsel, w))
								2'h0: s_nxt.kp_b = word;
								2'h1: s_nxt.ki_b = word;
								2'h2: s_nxt.kd_b = word;
								default: s_nxt.il_b = word;
							endcase
						end
					end
					`CMD_INT_MASK: s_nxt.mask = word[6:1];
					`CMD_INT_CLEAR: begin
						s_nxt.flags = s_r.flags & word[6:1];
					end
					`CMD_ERR_FLAG, `CMD_ERR_STOP: begin
						s_nxt.err_lim = word;
						s_nxt.err_en = 1'b1;
						s_nxt.err_stop = (s_r.cmd == `CMD_ERR_STOP);
					end
					default: begin
						if (s_r.word_idx == 4'h0) begin
							s_nxt.bp_pos[31:16] = word;
						end else begin
							s_nxt.bp_pos = {s_r.bp_pos[31:16], word};
							if (s_r.cmd == `CMD_BP_REL)
								s_nxt.bp_pos = s_r.pos_w +
									{s_r.bp_pos[31:16], word};
							s_nxt.bp_en = 1'b1;
						end
					end
				endcase
				if (s_nxt.words_left == 4'h0)
					s_nxt.phase = CMD_WAIT;
			end
		end

		// Events after clears, so a coinciding event is not lost
		if (traj_done_in) begin
			s_nxt.traj_done = 1'b1;
			s_nxt.flags[2] = 1'b1;
		end
		if (wrap_in)
			s_nxt.flags[4] = 1'b1;
		if (s_r.idx_armed && hl.index_edge) begin
			s_nxt.idx_pos = actual_position;
			s_nxt.flags[3] = 1'b1;
			s_nxt.idx_armed = 1'b0;
		end
		if (s_r.err_en && poserr_mag > {16'h0, s_r.err_lim}) begin
			s_nxt.flags[5] = 1'b1;
			s_nxt.err_en = 1'b0;
			if (s_r.err_stop)
				s_nxt.motor_off = 1'b1;
		end
		if (s_r.bp_en && actual_position == s_r.bp_pos) begin
			s_nxt.flags[6] = 1'b1;
			s_nxt.bp_en = 1'b0;
		end

		// Integral accumulator, clamped both ways to the working limit
		if (err_sample_valid) begin
			isum_t = s_r.isum + {{2{err_sample[15]}}, err_sample};
			if ($signed(isum_t) > $signed(il_ext))
				isum_t = il_ext;
			else if ($signed(isum_t) < -$signed(il_ext))
				isum_t = 18'h0 - il_ext;
			s_nxt.isum = isum_t;
		end

		// Derivative interval counter
		if (s_r.dcnt >= dend) begin
			s_nxt.dcnt = 20'h0;
			s_nxt.dtick = 1'b1;
		end else begin
			s_nxt.dcnt = s_r.dcnt + 20'h1;
		end

		s_nxt.host_int = |(s_nxt.flags & s_nxt.mask);
		s_nxt.out_byte = hl.read_status ? status_byte :
			s_nxt.rbuf[31:24];
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '{flags: 6'(`STATUS_RESET >> 1),
				motor_off: 1'b1, traj_done: 1'b1, phase: CMD_WAIT,
				default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	assign data_out          = s_r.out_byte;
	assign data_oe           = hl.drive;
	assign host_int          = s_r.host_int;
	assign acc_work          = s_r.acc_w;
	assign vel_work          = s_r.vel_w;
	assign pos_work          = s_r.pos_w;
	assign traj_ctrl_work    = s_r.tcw_w;
	assign start_pulse       = s_r.start_p;
	assign motor_off         = s_r.motor_off;
	assign proportional_gain = s_r.kp_w;
	assign integral_gain     = s_r.ki_w;
	assign derivative_gain   = s_r.kd_w;
	assign integration_limit = s_r.il_w;
	assign deriv_tick        = s_r.dtick;
	assign integral_sum      = s_r.isum[17] ? 16'(18'h0 - s_r.isum) :
		s_r.isum[15:0];

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence start_cmd;
		hl.cmd_strobe && hl.byte_val == `CMD_START;
	endsequence
	sequence commit_cmd;
		hl.cmd_strobe && hl.byte_val == `CMD_COMMIT_FILT;
	endsequence

	// Pin edges are ten clocks apart, so busy lasts exactly one cycle
	busy_after_byte_a: assert property (
		(hl.cmd_strobe || hl.data_strobe) |=> s_r.busy ##1 !s_r.busy)
		else $error("busy not raised after byte");
	accel_reject_a: assert property (
		start_cmd ##0 accel_block |=> s_r.flags[1] && !start_pulse)
		else $error("start with new acceleration not refused");
	start_commit_a: assert property (
		start_cmd ##0 !accel_block |=> start_pulse &&
			traj_ctrl_work == $past(s_r.tcw_buf))
		else $error("start did not commit trajectory");
	filter_hold_a: assert property (
		!(hl.cmd_strobe && hl.byte_val == `CMD_COMMIT_FILT) |=>
			proportional_gain == $past(proportional_gain))
		else $error("gain changed without commit");
	filter_commit_a: assert property (
		commit_cmd |=> proportional_gain == $past(s_r.kp_b) &&
			integration_limit == $past(s_r.il_b))
		else $error("commit did not copy gains");
	integral_clamp_a: assert property (
		err_sample_valid |=> $changed(integration_limit) ||
			integral_sum <= integration_limit)
		else $error("integral beyond limit");
	index_latch_a: assert property (
		s_r.idx_armed && hl.index_edge |=> s_r.flags[3] &&
			!s_r.idx_armed && s_r.idx_pos == $past(actual_position))
		else $error("index capture failed");
	host_int_gate_a: assert property (
		host_int == |(s_r.flags & s_r.mask))
		else $error("host interrupt not gated by mask");
	event_set_a: assert property (
		traj_done_in |=> s_r.flags[2] [*1] ##0 s_r.traj_done)
		else $error("completion event lost");
	status_read_a: assert property (
		hl.read_status && $stable(status_byte) |=>
			data_out == $past(status_byte))
		else $error("status byte not presented");
	err_limit_a: assert property (
		s_r.err_en && poserr_mag > {16'h0, s_r.err_lim} |=>
			s_r.flags[5] && (!$past(s_r.err_stop) || motor_off))
		else $error("error limit not flagged");
endmodule : motion_host_command_interface

/* File: verif/host_mcu.sv */
`timescale 1ns/100ps
module host_mcu (
	// Clock
	input  wire logic       core_clk,
	// Host pins
	output logic            cs_n,
	output logic            rd_n,
	output logic            wr_n,
	output logic            port_select_n,
	output logic [7:0]      data_in,
	input  wire logic [7:0] data_out
);
	int n_busy_timeout = 0;

	initial begin
		{cs_n, rd_n, wr_n, port_select_n} = 4'hF;
		data_in = 8'h00;
	end

	task step(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask : step

	////////////////////////////////////////////////////////////////////
	// Ten clocks a phase clears the three-stage pin synchroniser
	task put(input logic ps, input logic [7:0] b);
		port_select_n = ps;
		data_in = b;
		cs_n = 1'b0;
		step(10);
		wr_n = 1'b0;
		step(10);
		wr_n = 1'b1;
		step(10);
		cs_n = 1'b1;
		data_in = ~b; // Released bus, never the stale byte
		step(10);
	endtask : put

	task get(input logic ps, output logic [7:0] b);
		port_select_n = ps;
		cs_n = 1'b0;
		rd_n = 1'b0;
		step(10);
		b = data_out;
		rd_n = 1'b1;
		step(10);
		cs_n = 1'b1;
		step(10);
	endtask : get

	task wait_ready;
		logic [7:0] s;
		s = 8'hFF;
		for (int i = 0; i < 20 && s[0] !== 1'b0; i++) get(1'b0, s);
		if (s[0] !== 1'b0) n_busy_timeout++;
	endtask : wait_ready

	task cmd(input logic [7:0] c);
		wait_ready();
		put(1'b0, c);
	endtask : cmd

	task word(input logic [15:0] w);
		wait_ready();
		put(1'b1, w[15:8]);
		put(1'b1, w[7:0]);
	endtask : word

	task rd(input int n, output logic [31:0] v);
		logic [7:0] b;
		v = '0;
		wait_ready();
		for (int i = 0; i < n; i++) begin
			get(1'b1, b);
			v = {v[23:0], b};
		end
	endtask : rd
endmodule : host_mcu

/* File: verif/motion_host_command_interface_tb_top.sv */
`timescale 1ns/100ps
`include "motion_cfg.svh"
module motion_host_command_interface_tb_top;
	import motion_pkg::*;
	localparam int DSTEP = 4;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        cs_n, rd_n, wr_n, port_select_n, data_oe, host_int;
	logic        index_n, traj_done_in, wrap_in;
	logic        err_sample_valid, start_pulse, motor_off;
	logic        deriv_tick;
	logic [7:0]  data_in, data_out;
	logic [15:0] actual_velocity, err_sample, traj_ctrl_work;
	logic [15:0] proportional_gain, integral_gain, derivative_gain;
	logic [15:0] integration_limit, integral_sum;
	logic [31:0] desired_position, actual_position;
	logic [31:0] desired_velocity, acc_work, vel_work, pos_work;
	logic [31:0] seed = 32'h7C101219;
	int          n_mismatch = 0;
	int          checks_done = 0;
	int          n_starts = 0;
	int          oe_cycles = 0;

	always #25 core_clk = ~core_clk;

	// Pulse and enable widths, seen away from the launching edge
	always @(negedge core_clk) begin
		if (start_pulse === 1'b1) n_starts++;
		if (data_oe === 1'b1) oe_cycles++;
	end

	host_mcu host_mcu_i (.core_clk, .cs_n, .rd_n, .wr_n, .port_select_n,
		.data_in, .data_out);

	motion_host_command_interface #(.DERIV_STEP(DSTEP))
		motion_host_command_interface_i (.core_clk, .rst_b, .cs_n, .rd_n,
		.wr_n, .port_select_n, .data_in, .data_out, .data_oe, .host_int,
		.index_n, .desired_position, .actual_position, .desired_velocity,
		.actual_velocity, .traj_done_in, .wrap_in, .err_sample_valid,
		.err_sample, .acc_work, .vel_work, .pos_work, .traj_ctrl_work,
		.start_pulse, .motor_off, .proportional_gain, .integral_gain,
		.derivative_gain, .integration_limit, .deriv_tick, .integral_sum);

	////////////////////////////////////////////////////////////////////
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	function logic [31:0] tick_gap(input logic [7:0] d);
		return (32'(d) + 32'h1) * DSTEP;
	endfunction : tick_gap

	task chk(input string nm, input logic [31:0] got, input logic [31:0] e);
		checks_done++;
		if (got !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, got);
		end
	endtask : chk

	task give_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict

	task automatic pulse(ref logic s);
		@(posedge core_clk);
		#2 s = 1'b1;
		@(posedge core_clk);
		#2 s = 1'b0;
	endtask : pulse

	task wait_tick(output int n);
		n = 0;
		do begin
			@(posedge core_clk);
			#2 n++;
		end while (deriv_tick !== 1'b1 && n < 1200);
	endtask : wait_tick

	task stb(input string nm, input int i, input logic e);
		logic [7:0] s;
		host_mcu_i.get(1'b0, s);
		chk(nm, s[i], e);
	endtask : stb

	task rd_chk(input string nm, input logic [7:0] c, input int n,
		input logic [31:0] e);
		logic [31:0] v;
		host_mcu_i.cmd(c);
		host_mcu_i.rd(n, v);
		chk(nm, v, e);
	endtask : rd_chk

	task send32(input logic [31:0] v);
		host_mcu_i.word(v[31:16]);
		host_mcu_i.word(v[15:0]);
	endtask : send32

	task load_traj(input logic [15:0] w, input logic [31:0] a, b, c);
		host_mcu_i.cmd(`CMD_LOAD_TRAJ);
		host_mcu_i.word(w);
		if (w[`TCW_ACC_LOAD]) send32(a);
		if (w[`TCW_VEL_LOAD]) send32(b);
		if (w[`TCW_POS_LOAD]) send32(c);
	endtask : load_traj

	// Full run is near 10k cycles
	initial begin
		repeat (90000) @(posedge core_clk);
		n_mismatch++;
		give_verdict();
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0]  s, d;
		logic [15:0] g [4];
		logic [15:0] kp_old;
		logic [31:0] a, b, c, v;
		logic [3:0]  sel;
		int          n;
		{index_n, traj_done_in, wrap_in, err_sample_valid} = 4'h8;
		{actual_velocity, err_sample} = '0;
		{desired_position, actual_position, desired_velocity} = '0;
		repeat (4) @(posedge core_clk);
		#2 rst_b = 1'b1;
		host_mcu_i.step(2);
		host_mcu_i.get(1'b0, s);
		chk("status reset", s, `STATUS_RESET);
		chk("oe span", oe_cycles, 10);
		chk("motor_off reset", motor_off, 1'b1);
		host_mcu_i.cmd(`CMD_INT_MASK);
		host_mcu_i.word(16'h0000);
		host_mcu_i.cmd(`CMD_INT_CLEAR);
		host_mcu_i.word(16'h0000);
		host_mcu_i.get(1'b0, s);
		chk("status cleared", s, 8'h80);
		for (int i = 0; i < 2; i++) begin
			d = i ? 8'hFF : 8'(rnd() % 4);
			sel = i ? 4'h5 : 4'hF;
			kp_old = proportional_gain;
			foreach (g[k]) if (sel[3-k]) g[k] = 16'(rnd()) & 16'h7FFF;
			host_mcu_i.cmd(`CMD_LOAD_FILT);
			host_mcu_i.word({d, 4'h0, sel});
			foreach (g[k]) if (sel[3-k]) host_mcu_i.word(g[k]);
			chk("kp before commit", proportional_gain, kp_old);
			host_mcu_i.cmd(`CMD_COMMIT_FILT);
			chk("kp", proportional_gain, g[0]);
			chk("ki", integral_gain, g[1]);
			chk("kd", derivative_gain, g[2]);
			chk("il", integration_limit, g[3]);
			wait_tick(n);
			wait_tick(n);
			chk("tick gap", n, tick_gap(d));
		end
		err_sample = 16'h7F00 | (16'(rnd()) & 16'h00FF);
		repeat (4) pulse(err_sample_valid);
		rd_chk("sum high", `CMD_RD_INTEGRAL, 2, g[3]);
		err_sample = 16'h8000 | (16'(rnd()) & 16'h00FF);
		repeat (8) pulse(err_sample_valid);
		rd_chk("sum low", `CMD_RD_INTEGRAL, 2, g[3]);
		chk("sum port", integral_sum, g[3]);
		a = rnd();
		b = rnd();
		c = rnd();
		load_traj(16'h002A, a, b, c);
		chk("acc before start", acc_work, 32'h0);
		host_mcu_i.cmd(`CMD_START);
		chk("acc", acc_work, a);
		chk("vel", vel_work, b);
		chk("pos", pos_work, c);
		chk("tcw", traj_ctrl_work, 16'h002A);
		v = rnd();
		load_traj(16'h000C, 32'h0, v, 32'h0);
		host_mcu_i.cmd(`CMD_START);
		chk("vel relative", vel_work, b + v);
		v = rnd();
		load_traj(16'h0020, v, 32'h0, 32'h0);
		host_mcu_i.cmd(`CMD_START);
		chk("acc held", acc_work, a);
		chk("starts refused", n_starts, 2);
		stb("command error", 1, 1'b1);
		pulse(traj_done_in);
		stb("traj complete", 2, 1'b1);
		host_mcu_i.cmd(`CMD_START);
		chk("acc after done", acc_work, v);
		chk("starts", n_starts, 3);
		host_mcu_i.cmd(`CMD_INT_MASK);
		host_mcu_i.word(16'h0002);
		chk("host_int on", host_int, 1'b1);
		pulse(traj_done_in);
		host_mcu_i.get(1'b0, s);
		chk("masked shown", s[7:1], 7'h03);
		rd_chk("signals", `CMD_RD_SIGNALS, 2, 16'h8406);
		host_mcu_i.cmd(`CMD_INT_CLEAR);
		host_mcu_i.word(16'h00FD);
		chk("host_int off", host_int, 1'b0);
		host_mcu_i.get(1'b0, s);
		chk("clear bit1 only", s[2:1], 2'b10);
		pulse(wrap_in);
		stb("wraparound", 4, 1'b1);
		host_mcu_i.cmd(8'hFF);
		stb("unknown command", 1, 1'b1);
		host_mcu_i.cmd(`CMD_ARM_INDEX);
		host_mcu_i.cmd(`CMD_RD_SIGNALS);
		host_mcu_i.rd(2, v);
		chk("index armed", v[0], 1'b1);
		a = rnd();
		actual_position = a;
		index_n = 1'b0;
		host_mcu_i.step(10);
		index_n = 1'b1;
		host_mcu_i.step(2);
		actual_position = rnd();
		stb("index flag", 3, 1'b1);
		rd_chk("index", `CMD_RD_INDEX, 4, a);
		desired_position = rnd();
		desired_velocity = rnd();
		actual_velocity = 16'(rnd());
		rd_chk("des pos", `CMD_RD_DES_POS, 4, desired_position);
		rd_chk("act pos", `CMD_RD_ACT_POS, 4, actual_position);
		rd_chk("des vel", `CMD_RD_DES_VEL, 4, desired_velocity);
		rd_chk("act vel", `CMD_RD_ACT_VEL, 2, actual_velocity);
		// Error exactly at the limit must not fire, one more must
		for (int i = 0; i < 2; i++) begin
			b = rnd() & 32'h0FFF;
			desired_position = actual_position + b;
			host_mcu_i.cmd(i ? `CMD_ERR_STOP : `CMD_ERR_FLAG);
			host_mcu_i.word(b[15:0]);
			stb("error at limit", 5, 1'b0);
			desired_position = actual_position + b + 32'h1;
			stb("error flag", 5, 1'b1);
			chk("stop", motor_off, i[0]);
			host_mcu_i.cmd(`CMD_INT_CLEAR);
			host_mcu_i.word(16'h00DF);
		end
		for (int i = 0; i < 2; i++) begin
			a = rnd();
			v = i ? {{16{a[15]}}, a[15:0]} : {{2{a[29]}}, a[29:0]};
			host_mcu_i.cmd(i ? `CMD_BP_REL : `CMD_BP_ABS);
			send32(v);
			stb("bp not yet", 6, 1'b0);
			actual_position = v + (i ? c : 32'h0);
			stb("breakpoint", 6, 1'b1);
			host_mcu_i.cmd(`CMD_INT_CLEAR);
			host_mcu_i.word(16'h00BF);
		end
		chk("busy timeouts", host_mcu_i.n_busy_timeout, 0);
		give_verdict();
	end
endmodule : motion_host_command_interface_tb_top
